// >>> hw/lawwd_pkg.sv
// package: timing constants, state encoding and carrier types of the load aware watchdog
package lawwd_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // times in their natural units
    localparam int TRIG_TIMEOUT_MS = 96;
    localparam int PULSE_LOW_MS = 8;
    localparam int IGNORE_MS = 16;
    localparam int FILT_MIN_US = 100;
    localparam int FILT_MAX_US = 500;

    // cycle counts derived from the clock rate
    localparam int TRIG_TIMEOUT_CYC = TRIG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PULSE_LOW_CYC = PULSE_LOW_MS * 1000000 / CLK_PERIOD_NS;
    localparam int IGNORE_CYC = IGNORE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FILT_MIN_CYC = (FILT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_MAX_CYC = FILT_MAX_US * 1000 / CLK_PERIOD_NS;
    // filter settles midway between least and longest time
    localparam int FILT_DEF_CYC = (FILT_MIN_CYC + FILT_MAX_CYC) / 2;

    localparam int CNT_W = 24;
    localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

    typedef enum logic [3:0] {
        LAWWD_IGNORE = 4'h1,
        LAWWD_WAIT   = 4'h2,
        LAWWD_PULSE  = 4'h4,
        LAWWD_OFF    = 4'h8
    } lawwd_state_t;

    // synchronised comparator indications
    typedef struct packed {
        logic low_current;
        logic pin_disable_level;
    } lawwd_ind_t;

endpackage : lawwd_pkg

// >>> hw/lawwd_filter.sv
// persistence filter: output follows input once it has held for a count of cycles
`timescale 1ns/1ps
module lawwd_filter #(
    parameter int FILT_CYC = lawwd_pkg::FILT_DEF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic raw,
    output logic filt
);
    import lawwd_pkg::*;

    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic filt_r, filt_nxt;

    always_comb begin
        cnt_nxt = CNT_RST;
        filt_nxt = filt_r;
        if (raw != filt_r) begin
            if (cnt_r >= CNT_W'(FILT_CYC - 1)) begin
                filt_nxt = raw;
            end else begin
                cnt_nxt = cnt_r + 24'h000001;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= CNT_RST;
            filt_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            filt_r <= filt_nxt;
        end
    end

    assign filt = filt_r;

endmodule : lawwd_filter

// >>> hw/lawwd_top.sv
// load aware timeout watchdog: trigger supervision, filtered deactivation, output pulse
// Overview of operation
// R1: one fixed trigger timeout of 96 ms for the controller to trigger.
// R2: persistent low current makes the watchdog inactive, no timeout pulse.
// R3: low current shorter than the least filter time leaves state unchanged.
// R4: return to active needs high current persisting through the same filter.
// R5: a missed trigger drives the active low output low.
// R6: deactivated while waiting with output high, output stays high.
// R7: deactivated in a pulse for long, pulse completes then output goes high.
// R8: deactivated in a pulse for short, output stays low throughout.
// R9: deactivated during ignore window after pulse, output stays high.
// R10: leaving inactive runs an ignore window, then a fresh timeout.
// R11: persisting disable level on trigger pin deactivates the watchdog.
// R12: disable level ending reactivates with ignore window, same output cases.
// R13: controller uses disable level only outside normal operation.
// R14: a falling edge on the trigger input services the watchdog.
// R15: current filter accepts no change before 100 us, completes by 500 us.
// R16: timeout low pulse is 8 ms long.
// R17: ignore window is 16 ms long.
// R18: edges in ignore window are ignored; internal counter timebase used.
`timescale 1ns/1ps
module lawwd_top #(
    parameter int TRIG_CYC = lawwd_pkg::TRIG_TIMEOUT_CYC,
    parameter int PULSE_CYC = lawwd_pkg::PULSE_LOW_CYC,
    parameter int IGN_CYC = lawwd_pkg::IGNORE_CYC,
    parameter int FILT_CYC = lawwd_pkg::FILT_DEF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic trigger_input,
    input wire lawwd_pkg::lawwd_ind_t ind,
    output logic supervisor_output_n,
    output logic wd_active
);
    import lawwd_pkg::*;

    // counter has reached the last cycle of a span
    function automatic logic lawwd_done(input logic [CNT_W-1:0] cnt, input int lim);
        return cnt >= CNT_W'(lim - 1);
    endfunction : lawwd_done

    // ------------------------------------------------------------
    // deactivation filters
    // ------------------------------------------------------------
    logic low_cur_f, dis_f, inactive;

    lawwd_filter #(.FILT_CYC(FILT_CYC)) u_cur_filt ( // R2 R3 R4 R15
        .clk(clk),
        .resetn(resetn),
        .raw(ind.low_current),
        .filt(low_cur_f)
    );

    lawwd_filter #(.FILT_CYC(FILT_CYC)) u_dis_filt ( // R11 R12
        .clk(clk),
        .resetn(resetn),
        .raw(ind.pin_disable_level),
        .filt(dis_f)
    );

    assign inactive = low_cur_f | dis_f;

    // ------------------------------------------------------------
    // trigger edge
    // ------------------------------------------------------------
    logic trig_d_r, trig_d_nxt, fall;

    always_comb begin
        trig_d_nxt = trigger_input;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_d_r <= 1'b1;
        end else begin
            trig_d_r <= trig_d_nxt;
        end
    end

    // disable level reads as neither high nor low, so no edge while it stands
    assign fall = trig_d_r & ~trigger_input & ~ind.pin_disable_level; // R14

    // ------------------------------------------------------------
    // main state machine
    // ------------------------------------------------------------
    lawwd_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CNT_W-1:0] pls_r, pls_nxt;
    logic out_r, out_nxt;
    logic act_r, act_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 24'h000001;
        pls_nxt = pls_r;
        out_nxt = out_r;
        act_nxt = ~inactive;
        case (state_r)
            LAWWD_IGNORE: begin
                out_nxt = 1'b1;
                if (inactive) begin
                    state_nxt = LAWWD_OFF; // R9
                    cnt_nxt = CNT_RST;
                end else if (lawwd_done(cnt_r, IGN_CYC)) begin // R17 R18
                    state_nxt = LAWWD_WAIT;
                    cnt_nxt = CNT_RST;
                end
            end
            LAWWD_WAIT: begin
                out_nxt = 1'b1;
                if (inactive) begin
                    state_nxt = LAWWD_OFF; // R6
                    cnt_nxt = CNT_RST;
                end else if (fall) begin
                    cnt_nxt = CNT_RST; // R14
                end else if (lawwd_done(cnt_r, TRIG_CYC)) begin // R1
                    state_nxt = LAWWD_PULSE;
                    out_nxt = 1'b0; // R5
                    cnt_nxt = CNT_RST;
                    pls_nxt = CNT_RST;
                end
            end
            LAWWD_PULSE: begin
                pls_nxt = pls_r + 24'h000001;
                if (lawwd_done(pls_r, PULSE_CYC)) begin // R16
                    out_nxt = 1'b1;
                    pls_nxt = pls_r;
                    if (inactive) begin
                        state_nxt = LAWWD_OFF; // R7
                    end else begin
                        state_nxt = LAWWD_IGNORE;
                    end
                    cnt_nxt = CNT_RST;
                end else if (inactive) begin
                    out_nxt = 1'b0; // R8
                end
            end
            LAWWD_OFF: begin
                cnt_nxt = CNT_RST;
                out_nxt = 1'b1;
                if (!inactive) begin
                    state_nxt = LAWWD_IGNORE; // R10 R12
                end
            end
            default: begin
                state_nxt = LAWWD_IGNORE;
                cnt_nxt = CNT_RST;
                out_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= LAWWD_IGNORE;
            cnt_r <= CNT_RST;
            pls_r <= CNT_RST;
            out_r <= 1'b1;
            act_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pls_r <= pls_nxt;
            out_r <= out_nxt;
            act_r <= act_nxt;
        end
    end

    assign supervisor_output_n = out_r;
    assign wd_active = act_r;

    // ------------------------------------------------------------
    // persistence counters for the filter checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cur_run_r, cur_run_nxt;
    logic [CNT_W-1:0] cur_quiet_r, cur_quiet_nxt;

    always_comb begin
        cur_run_nxt = CNT_RST;
        cur_quiet_nxt = CNT_RST;
        if (ind.low_current) begin
            cur_run_nxt = (&cur_run_r) ? cur_run_r : cur_run_r + 24'h000001;
        end else begin
            cur_quiet_nxt = (&cur_quiet_r) ? cur_quiet_r : cur_quiet_r + 24'h000001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur_run_r <= CNT_RST;
            cur_quiet_r <= CNT_RST;
        end else begin
            cur_run_r <= cur_run_nxt;
            cur_quiet_r <= cur_quiet_nxt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_off_stays;
        state_r == LAWWD_OFF && inactive;
    endsequence

    sequence s_off_then_high;
        state_r == LAWWD_OFF ##1 supervisor_output_n;
    endsequence

    timeout_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R5
        (state_r == LAWWD_WAIT && !inactive && !fall && cnt_r == CNT_W'(TRIG_CYC - 1))
        |=> (state_r == LAWWD_PULSE && !supervisor_output_n))
        else $error("missed trigger did not start low pulse");

    timeout_len_a: assert property (@(posedge clk) disable iff (!resetn) // R1
        (state_r == LAWWD_WAIT) |-> (cnt_r < CNT_W'(TRIG_CYC)))
        else $error("trigger timeout counter overran");

    off_high_a: assert property (@(posedge clk) disable iff (!resetn) // R6
        s_off_stays |=> supervisor_output_n)
        else $error("output low while inactive outside pulse");

    pulse_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R8
        (state_r == LAWWD_PULSE && pls_r < CNT_W'(PULSE_CYC - 1)) |=> !supervisor_output_n)
        else $error("low pulse released early");

    pulse_end_a: assert property (@(posedge clk) disable iff (!resetn) // R7
        (state_r == LAWWD_PULSE && pls_r == CNT_W'(PULSE_CYC - 1) && inactive)
        |=> (state_r == LAWWD_OFF && supervisor_output_n))
        else $error("pulse end while inactive mishandled");

    ignore_wake_a: assert property (@(posedge clk) disable iff (!resetn) // R10
        (state_r == LAWWD_OFF && !inactive) |=> (state_r == LAWWD_IGNORE && cnt_r == CNT_RST))
        else $error("reactivation did not start ignore window");

    ignore_edge_a: assert property (@(posedge clk) disable iff (!resetn) // R18
        (state_r == LAWWD_IGNORE && !inactive && cnt_r < CNT_W'(IGN_CYC - 1))
        |=> (state_r == LAWWD_IGNORE && $stable(pls_r)))
        else $error("ignore window left early");

    ignore_deact_a: assert property (@(posedge clk) disable iff (!resetn) // R9
        (state_r == LAWWD_IGNORE && inactive) |=> s_off_then_high)
        else $error("deactivation in ignore window mishandled");

    service_a: assert property (@(posedge clk) disable iff (!resetn) // R14
        (state_r == LAWWD_WAIT && !inactive && fall) |=> (cnt_r == CNT_RST))
        else $error("falling edge did not restart timeout");

    short_drop_a: assert property (@(posedge clk) disable iff (!resetn) // R3
        ($rose(ind.low_current) && !low_cur_f) ##1 !ind.low_current |=> !low_cur_f)
        else $error("short current drop changed state");

    wait_hold_a: assert property (@(posedge clk) disable iff (!resetn) // R6
        (state_r == LAWWD_WAIT && inactive) |=> (state_r == LAWWD_OFF && supervisor_output_n))
        else $error("deactivation while waiting mishandled");

    off_out_a: assert property (@(posedge clk) disable iff (!resetn) // R2
        (state_r == LAWWD_OFF) |-> supervisor_output_n)
        else $error("output low while watchdog inactive");

    active_low_a: assert property (@(posedge clk) disable iff (!resetn) // R2
        inactive |=> !wd_active)
        else $error("active flag high while inactive");

    active_high_a: assert property (@(posedge clk) disable iff (!resetn) // R4
        !inactive |=> wd_active)
        else $error("active flag low while active");

    pulse_begin_a: assert property (@(posedge clk) disable iff (!resetn) // R16
        $fell(supervisor_output_n) |-> (state_r == LAWWD_PULSE && pls_r == CNT_RST))
        else $error("low pulse began outside pulse state");

    pulse_release_a: assert property (@(posedge clk) disable iff (!resetn) // R16
        (state_r == LAWWD_PULSE && pls_r == CNT_W'(PULSE_CYC - 1)) |=> supervisor_output_n)
        else $error("low pulse not released at its end");

    pulse_count_a: assert property (@(posedge clk) disable iff (!resetn) // R16
        (state_r == LAWWD_PULSE) |-> (pls_r < CNT_W'(PULSE_CYC)))
        else $error("low pulse counter overran");

    ignore_len_a: assert property (@(posedge clk) disable iff (!resetn) // R17
        (state_r == LAWWD_IGNORE) |-> (cnt_r < CNT_W'(IGN_CYC)))
        else $error("ignore window counter overran");

    ignore_end_a: assert property (@(posedge clk) disable iff (!resetn) // R17
        (state_r == LAWWD_IGNORE && !inactive && cnt_r == CNT_W'(IGN_CYC - 1))
        |=> (state_r == LAWWD_WAIT && cnt_r == CNT_RST))
        else $error("ignore window end did not start timeout");

    ignore_fall_a: assert property (@(posedge clk) disable iff (!resetn) // R18
        (state_r == LAWWD_IGNORE && !inactive && fall && cnt_r < CNT_W'(IGN_CYC - 1))
        |=> (cnt_r == $past(cnt_r) + 24'h000001))
        else $error("edge in ignore window restarted the count");

    fall_seen_a: assert property (@(posedge clk) disable iff (!resetn) // R14
        ($fell(trigger_input) && !ind.pin_disable_level) |-> fall)
        else $error("falling trigger edge not detected");

    dis_off_a: assert property (@(posedge clk) disable iff (!resetn) // R11
        (state_r != LAWWD_PULSE && dis_f) |=> (state_r == LAWWD_OFF))
        else $error("filtered disable level did not deactivate");

    cur_off_a: assert property (@(posedge clk) disable iff (!resetn) // R2
        (state_r != LAWWD_PULSE && low_cur_f) |=> (state_r == LAWWD_OFF))
        else $error("filtered low current did not deactivate");

    cur_persist_a: assert property (@(posedge clk) disable iff (!resetn) // R15
        $rose(low_cur_f) |-> (cur_run_r >= CNT_W'(FILT_CYC)))
        else $error("low current accepted before filter time");

    cur_return_a: assert property (@(posedge clk) disable iff (!resetn) // R4
        $fell(low_cur_f) |-> (cur_quiet_r >= CNT_W'(FILT_CYC)))
        else $error("high current accepted before filter time");

    dis_wake_a: assert property (@(posedge clk) disable iff (!resetn) // R12
        ($fell(dis_f) && !low_cur_f && state_r == LAWWD_OFF) |=> (state_r == LAWWD_IGNORE))
        else $error("end of disable level did not reactivate");

    low_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // R5
        !supervisor_output_n |-> (state_r == LAWWD_PULSE))
        else $error("output low outside timeout pulse");

endmodule : lawwd_top

// >>> test/lawwd_mcu_model.sv
// partner model: controller that services the watchdog trigger pin
`timescale 1ns/1ps
module lawwd_mcu_model #(
    parameter int HALF = 10
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serve,
    input wire logic flash,
    output logic trigger_input,
    output logic pin_disable_level
);
    int cnt;
    // -------------------------------
    // trigger toggling and disable band
    // -------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
            trigger_input <= 1'b1;
        end else if (serve && !flash) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                trigger_input <= ~trigger_input;
            end
        end
    end
    // disable band only while reprogramming, as the bench commands
    assign pin_disable_level = flash;
endmodule : lawwd_mcu_model

// >>> test/tb.sv
// testbench: table of watchdog cases, then reset and mid-run reset checks
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin fails++; \
    $display("BAD %s exp %0d got %0d", nm, e, s); end end
module tb;
    import lawwd_pkg::*;
    localparam int TR = 200;
    localparam int PU = 20;
    localparam int IG = 40;
    localparam int FI = 5;
    localparam int BK = 405 + IG + TR;
    typedef struct {int srv; bit pin; int st; int len; int win; int nlow; int first; bit off;}
        lawwd_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic lc = 1'b0;
    logic serve = 1'b0;
    logic flash = 1'b0;
    logic trig;
    logic pd;
    logic out_n;
    logic act;
    lawwd_ind_t ind;
    int fails = 0;
    int n_compared = 0;
    int nlow;
    int first;
    bit off;
    lawwd_row_t rows [9] = '{
        '{0, 0, 0, 0, 300, PU, IG + TR, 0},
        '{35, 0, 0, 0, 300, PU, IG + TR, 0},
        '{600, 0, 0, 0, 600, 0, -1, 0},
        '{0, 0, 100, 300, 700, PU, BK, 1},
        '{0, 1, 100, 300, 700, PU, BK, 1},
        '{0, 0, 100, 3, 300, PU, IG + TR, 0},
        '{0, 0, 245, 100, 300, PU, IG + TR, 1},
        '{0, 0, 242, 8, 300, PU, IG + TR, 1},
        '{0, 0, 265, 200, 300, PU, IG + TR, 1}
    };
    assign ind = '{low_current: lc, pin_disable_level: pd};
    always #5 clk = ~clk;
    lawwd_top #(.TRIG_CYC(TR), .PULSE_CYC(PU), .IGN_CYC(IG), .FILT_CYC(FI)) i_dut (
        .clk(clk),
        .resetn(resetn),
        .trigger_input(trig),
        .ind(ind),
        .supervisor_output_n(out_n),
        .wd_active(act)
    );
    lawwd_mcu_model #(.HALF(10)) i_mcu (
        .clk(clk),
        .resetn(resetn),
        .serve(serve),
        .flash(flash),
        .trigger_input(trig),
        .pin_disable_level(pd)
    );
    // -------------------------------
    // helpers
    // -------------------------------
    task automatic close_out();
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic run_row(input lawwd_row_t r);
        bit in_on;
        @(posedge clk);
        resetn <= 1'b0;
        lc <= 1'b0;
        flash <= 1'b0;
        serve <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        nlow = 0;
        first = -1;
        off = 0;
        for (int c = 0; c < r.win; c++) begin
            @(posedge clk);
            in_on = (c >= r.st) && (c < r.st + r.len);
            serve <= (c < r.srv);
            lc <= in_on && !r.pin;
            flash <= in_on && r.pin;
            #1;
            if (out_n === 1'b0) begin
                nlow++;
                if (first < 0) first = c;
            end
            if (c > 2 && act === 1'b0) off = 1;
        end
        `CHK("low cycles", r.nlow, nlow)
        `CHK("pulse start", 1, (first >= r.first - 4 && first <= r.first + 4))
        `CHK("inactive seen", r.off, off)
    endtask : run_row
    // -------------------------------
    // main sequence and watchdog
    // -------------------------------
    initial begin
        foreach (rows[i]) run_row(rows[i]);
        @(posedge clk);
        resetn <= 1'b0;
        lc <= 1'b0;
        flash <= 1'b0;
        serve <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK("reset out_n", 1'b1, out_n) // RESET
        `CHK("reset active", 1'b0, act) // RESET
        resetn <= 1'b1;
        repeat (IG + TR + 8) @(posedge clk);
        #1;
        `CHK("pulse low", 1'b0, out_n)
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("mid reset out_n", 1'b1, out_n) // RESET
        `CHK("mid reset active", 1'b0, act) // RESET
        close_out();
    end
    initial begin
        #200000;
        fails++;
        close_out();
    end
endmodule : tb
